// ---- verilog/iks_regs.svh ----
// Timing constants for the inductive key scan core
`ifndef IKS_REGS_SVH
`define IKS_REGS_SVH
`define IKS_CLK_MHZ        25
`define IKS_T_CYCLE_US     60
`define IKS_T_DIGITAL_US   280
`define IKS_T_UPDATE_US    400
`define IKS_T_SETUP_SYNC_US  15
`define IKS_T_SETUP_ASYNC_US 20
`define IKS_T_CONV_MIN_US  36
`define IKS_T_CONV_MAX_US  110
`define IKS_TARGET_MIN     150
`define IKS_TARGET_MAX     800
`define IKS_TARGET_DEF     350
`define IKS_CYC_DIGITAL    (`IKS_T_DIGITAL_US * `IKS_CLK_MHZ)
`define IKS_CYC_SETUP_SYNC  (`IKS_T_SETUP_SYNC_US * `IKS_CLK_MHZ)
`define IKS_CYC_SETUP_ASYNC (`IKS_T_SETUP_ASYNC_US * `IKS_CLK_MHZ)
`define IKS_NUM_KEYS       4
`define IKS_SYNC_BIT       7
`endif

// ---- verilog/iks_pkg.sv ----
// Types for the inductive key scan core
`default_nettype none
package iks_pkg;
  typedef enum logic [2:0] {
    IKS_IDLE    = 3'b000,
    IKS_CONV_A  = 3'b001,
    IKS_CONV_B  = 3'b011,
    IKS_DIGITAL = 3'b010,
    IKS_WAIT    = 3'b110
  } iks_state_t;
  typedef struct packed {
    logic selectLineA;
    logic selectLineB;
  } iks_sel_t;
  typedef struct packed {
    logic dataoutLineA;
    logic dataoutLineB;
  } iks_dout_t;
endpackage : iks_pkg
`default_nettype wire

// ---- verilog/iks_timer.sv ----
// Down counter that pulses done when a loaded count expires
`timescale 1ns/10ps
`default_nettype none
module iks_timer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [15:0] count,
  output logic             busy,
  output logic             done
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= count;
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          done <= 1'b1;
        end
      end
    end
  end
  assign busy = (cnt_r != 16'h0000);
endmodule : iks_timer
`default_nettype wire

// ---- verilog/iks_core.sv ----
// Key update sequencer and select-driven data-out mux
// What this block does
// - Four keys, one per channel 0..3, are reported on the two data-out lines.
// - Each key update converts channels 0/1 in a first cycle, then channels 2/3 in a second.
// - At target 350 each conversion cycle lasts 60 us, digital processing 280 us, update 400 us.
// - A full host scan lasts at least four select setup intervals, set by conversion mode.
// - With the sync-on-key-scan bit set the setup interval is 15 us (60 us scan).
// - With that bit cleared the setup interval is 20 us (80 us scan).
// - Conversion time grows with count target, from 36 us at 150 to 110 us at 800.
// - In sync mode a press missed by one update is measured in the next, worst case 860 us.
// - Selects low show the reset flag on line a; select a high shows ch0/1; select b alone ch2/3.
// - A high data-out means trigger reached, or for the reset slot reset acknowledged.
`timescale 1ns/10ps
`default_nettype none
`include "iks_regs.svh"
module iks_core
  import iks_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire iks_sel_t        sel,
  input  wire logic            syncOnKeyScan,
  input  wire logic [9:0]      countTarget,
  input  wire logic [3:0]      keyTrigger,
  input  wire logic            resetAck,
  output iks_dout_t            dout,
  output logic                 keysUpdated,
  output logic [15:0]          setupCycles,
  output logic [1:0]           convCycle
);
  localparam logic [15:0] CycDigital = 16'(`IKS_CYC_DIGITAL);
  localparam logic [15:0] CycSetupS  = 16'(`IKS_CYC_SETUP_SYNC);
  localparam logic [15:0] CycSetupA  = 16'(`IKS_CYC_SETUP_ASYNC);
  localparam int          ConvMinCyc = `IKS_T_CONV_MIN_US * `IKS_CLK_MHZ;
  localparam int          ConvDefCyc = `IKS_T_CYCLE_US * `IKS_CLK_MHZ;
  localparam int          ConvMaxCyc = `IKS_T_CONV_MAX_US * `IKS_CLK_MHZ;

  iks_state_t  state_r;
  iks_state_t  state_nxt;
  logic [3:0]  sampled_r;
  logic [3:0]  keys_r;
  logic        selPrev_r;
  logic        scanEvent;
  logic        tLoad;
  logic [15:0] tCount;
  logic [15:0] phaseCnt_r;
  logic        tBusy;
  logic        tDone;
  logic [15:0] convCyc;
  logic [31:0] convCalc;
  logic [9:0]  tgtClamp;

  // Conversion time interpolated piecewise linearly across the clamped target range; keeps area small
  always_comb begin
    tgtClamp = countTarget;
    if (countTarget < 10'(`IKS_TARGET_MIN)) tgtClamp = 10'(`IKS_TARGET_MIN);
    if (countTarget > 10'(`IKS_TARGET_MAX)) tgtClamp = 10'(`IKS_TARGET_MAX);
    // Two segments meet at the default target so that point is exact
    if (tgtClamp <= 10'(`IKS_TARGET_DEF)) begin
      convCalc = 32'(ConvMinCyc) + (32'(tgtClamp - 10'(`IKS_TARGET_MIN)) * 32'(ConvDefCyc - ConvMinCyc))
                 / 32'(`IKS_TARGET_DEF - `IKS_TARGET_MIN);
    end else begin
      convCalc = 32'(ConvDefCyc) + (32'(tgtClamp - 10'(`IKS_TARGET_DEF)) * 32'(ConvMaxCyc - ConvDefCyc))
                 / 32'(`IKS_TARGET_MAX - `IKS_TARGET_DEF);
    end
    convCyc = convCalc[15:0];
  end

  // A scan starts on the falling edge to both selects low
  assign scanEvent = selPrev_r && !(sel.selectLineA || sel.selectLineB);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) selPrev_r <= 1'b0;
    else selPrev_r <= sel.selectLineA || sel.selectLineB;
  end

  iks_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (tLoad),
    .count (tCount),
    .busy  (tBusy),
    .done  (tDone)
  );

  // Sequencer: in sync mode each update after the first from reset waits for a key scan
  always_comb begin
    state_nxt = state_r;
    tLoad     = 1'b0;
    // The timer also spends the load cycle, so one less is loaded
    tCount    = convCyc - 16'h0001;
    case (state_r)
      IKS_IDLE: begin
        state_nxt = IKS_CONV_A;
        tLoad     = 1'b1;
      end
      IKS_CONV_A: if (tDone) begin
        state_nxt = IKS_CONV_B;
        tLoad     = 1'b1;
      end
      IKS_CONV_B: if (tDone) begin
        state_nxt = IKS_DIGITAL;
        tLoad     = 1'b1;
        tCount    = CycDigital - 16'h0001;
      end
      IKS_DIGITAL: if (tDone) begin
        state_nxt = syncOnKeyScan ? IKS_WAIT : IKS_CONV_A;
        tLoad     = !syncOnKeyScan;
      end
      IKS_WAIT: if (scanEvent || !syncOnKeyScan) begin
        state_nxt = IKS_CONV_A;
        tLoad     = 1'b1;
      end
      default: state_nxt = IKS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_r <= IKS_IDLE;
    else state_r <= state_nxt;
  end

  // Cycles spent in the current phase; only the length check reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) phaseCnt_r <= 16'h0000;
    else if (state_nxt != state_r) phaseCnt_r <= 16'h0000;
    else phaseCnt_r <= phaseCnt_r + 16'h0001;
  end

  // Each channel pair is captured at the end of its own cycle; later presses wait a full update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sampled_r <= 4'h0;
    else if (state_r == IKS_CONV_A && tDone) sampled_r[1:0] <= keyTrigger[1:0];
    else if (state_r == IKS_CONV_B && tDone) sampled_r[3:2] <= keyTrigger[3:2];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keys_r      <= 4'h0;
      keysUpdated <= 1'b0;
    end else begin
      keysUpdated <= (state_r == IKS_DIGITAL) && tDone;
      if (state_r == IKS_DIGITAL && tDone) keys_r <= sampled_r;
    end
  end

  // Setup interval reported for the host side of the scan timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) setupCycles <= CycSetupA;
    else setupCycles <= syncOnKeyScan ? CycSetupS : CycSetupA;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) convCycle <= 2'h0;
    else convCycle <= (state_nxt == IKS_CONV_A) ? 2'h1 : (state_nxt == IKS_CONV_B) ? 2'h2 : 2'h0;
  end

  // Data-out mux; select b high with select a high still shows channels 0/1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else if (sel.selectLineA) begin
      dout <= '{dataoutLineA: keys_r[0], dataoutLineB: keys_r[1]};
    end else if (sel.selectLineB) begin
      dout <= '{dataoutLineA: keys_r[2], dataoutLineB: keys_r[3]};
    end else begin
      dout <= '{dataoutLineA: resetAck, dataoutLineB: 1'b0};
    end
  end

  property p_setup_mode;
    @(posedge clk) disable iff (!rst_n)
    $changed(syncOnKeyScan) |=> setupCycles == (syncOnKeyScan ? CycSetupS : CycSetupA);
  endproperty
  a_setup_mode: assert property (p_setup_mode) else $error("setup interval does not follow mode");

  property p_keys_stable;
    @(posedge clk) disable iff (!rst_n)
    !(state_r == IKS_DIGITAL && tDone) |=> $stable(keys_r);
  endproperty
  a_keys_stable: assert property (p_keys_stable) else $error("keys changed outside update end");

  property p_order;
    @(posedge clk) disable iff (!rst_n)
    (state_r == IKS_CONV_A && tDone) |=> state_r == IKS_CONV_B;
  endproperty
  a_order: assert property (p_order) else $error("second conversion cycle did not follow first");

  property p_digital_len;
    @(posedge clk) disable iff (!rst_n)
    (state_r == IKS_CONV_B && tDone) |=> (state_r == IKS_DIGITAL) [*8];
  endproperty
  a_digital_len: assert property (p_digital_len) else $error("digital phase too short");

  property p_mux_a;
    @(posedge clk) disable iff (!rst_n)
    sel.selectLineA |=> dout.dataoutLineA == $past(keys_r[0]) && dout.dataoutLineB == $past(keys_r[1]);
  endproperty
  a_mux_a: assert property (p_mux_a) else $error("channels 0/1 not presented");

  property p_mux_b;
    @(posedge clk) disable iff (!rst_n)
    (!sel.selectLineA && sel.selectLineB) |=> dout.dataoutLineA == $past(keys_r[2])
                                              && dout.dataoutLineB == $past(keys_r[3]);
  endproperty
  a_mux_b: assert property (p_mux_b) else $error("channels 2/3 not presented");

  property p_reset_slot;
    @(posedge clk) disable iff (!rst_n)
    (!sel.selectLineA && !sel.selectLineB) |=> dout.dataoutLineA == $past(resetAck) && !dout.dataoutLineB;
  endproperty
  a_reset_slot: assert property (p_reset_slot) else $error("reset flag not presented");

  property p_sync_wait;
    @(posedge clk) disable iff (!rst_n)
    (state_r == IKS_WAIT && syncOnKeyScan && !scanEvent) |=> state_r == IKS_WAIT;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync mode ran without a key scan");

  property p_update_pulse;
    @(posedge clk) disable iff (!rst_n)
    keysUpdated |-> $past(state_r) == IKS_DIGITAL;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update pulse without processing");

  property p_digital_exact;
    @(posedge clk) disable iff (!rst_n)
    (state_r == IKS_DIGITAL && tDone) |-> phaseCnt_r == CycDigital - 16'h0001;
  endproperty
  a_digital_exact: assert property (p_digital_exact) else $error("digital phase length wrong");

  property p_timer_busy;
    @(posedge clk) disable iff (!rst_n)
    (state_r == IKS_CONV_A || state_r == IKS_CONV_B || state_r == IKS_DIGITAL) |-> (tBusy || tDone);
  endproperty
  a_timer_busy: assert property (p_timer_busy) else $error("phase running without timer");
endmodule : iks_core
`default_nettype wire

// ---- testbench/iks_host_model.sv ----
// Host model that scans one matrix cell through the select lines
`timescale 1ns/10ps
`default_nettype none
module iks_host_model
  import iks_pkg::*;
(
  input  wire logic      clk,
  input  wire iks_dout_t dout,
  output var iks_sel_t   sel,
  output logic [4:0]     seen
);
  // Idles with select a high so a scan always starts with a falling edge
  initial begin
    sel = 2'b10;
    seen = 5'h00;
  end
  // Each slot is held a full setup interval, four in all
  task automatic scan(input int setupCyc);
    @(negedge clk) sel = 2'b00;
    repeat (setupCyc) @(negedge clk);
    seen[4] = dout.dataoutLineA;
    sel = 2'b10;
    repeat (setupCyc) @(negedge clk);
    seen[3:2] = dout;
    sel = 2'b01;
    repeat (setupCyc) @(negedge clk);
    seen[1:0] = dout;
    sel = 2'b10;
    repeat (setupCyc) @(negedge clk);
  endtask : scan
endmodule : iks_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the key scan core
`timescale 1ns/10ps
`default_nettype none
`include "iks_regs.svh"
module tb_top
  import iks_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        syncOnKeyScan = 1'b0;
  logic [9:0]  countTarget = 10'(`IKS_TARGET_DEF);
  logic [3:0]  keyTrigger = 4'h0;
  logic        resetAck = 1'b0;
  iks_sel_t    sel;
  iks_dout_t   dout;
  logic        keysUpdated;
  logic [15:0] setupCycles;
  logic [1:0]  convCycle;
  logic [4:0]  seen;
  int          mismatches = 0;
  int          check_count = 0;
  always #20 clk = ~clk;
  iks_core dut_u (.clk(clk), .rst_n(rst_n), .sel(sel), .syncOnKeyScan(syncOnKeyScan),
    .countTarget(countTarget), .keyTrigger(keyTrigger), .resetAck(resetAck), .dout(dout),
    .keysUpdated(keysUpdated), .setupCycles(setupCycles), .convCycle(convCycle));
  iks_host_model host_u (.clk(clk), .dout(dout), .sel(sel), .seen(seen));
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic wait_upd();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (keysUpdated !== 1'b1 && n < 20000);
    cmp("keysUpdated", 16'h0001, {15'h0, keysUpdated});
  endtask : wait_upd
  task automatic t_mode();
    cmp("setupAsync", 16'(`IKS_CYC_SETUP_ASYNC), setupCycles);
    @(negedge clk) syncOnKeyScan = 1'b1;
    repeat (3) @(negedge clk);
    cmp("setupSync", 16'(`IKS_CYC_SETUP_SYNC), setupCycles);
    syncOnKeyScan = 1'b0;
    repeat (3) @(negedge clk);
    cmp("setupBack", 16'(`IKS_CYC_SETUP_ASYNC), setupCycles);
  endtask : t_mode
  // The refresh after a target change mixes old and new cycle lengths, so the next one is timed
  task automatic t_period(input logic [9:0] tgt, input int conv);
    int n;
    n = 0;
    countTarget = tgt;
    wait_upd();
    do begin
      @(negedge clk);
      n++;
      if (n == 10) cmp("convCycle1", 16'h0001, {14'h0, convCycle});
      if (n == conv + 10) cmp("convCycle2", 16'h0002, {14'h0, convCycle});
      if (n == 2 * conv + 10) cmp("convCycleDig", 16'h0000, {14'h0, convCycle});
    end while (keysUpdated !== 1'b1 && n < 20000);
    cmp("period", 16'(2 * conv + `IKS_CYC_DIGITAL), n[15:0]);
  endtask : t_period
  task automatic t_keys(input logic [3:0] k, input logic ack);
    keyTrigger = k;
    resetAck = ack;
    wait_upd();
    wait_upd();
    // Keys must hold until the next refresh; the reset flag is shown live
    keyTrigger = ~k;
    resetAck = ~ack;
    host_u.scan(`IKS_CYC_SETUP_ASYNC);
    cmp("scan", {11'h0, ~ack, k[0], k[1], k[2], k[3]}, {11'h0, seen});
  endtask : t_keys
  // Sync mode: no refresh without a scan; a press made while waiting shows on the scan after the update
  task automatic t_sync(input logic [3:0] old, input logic [3:0] k);
    int n;
    int expLat;
    n = 0;
    // Update starts one edge after the first select fall; the second scan starts one negedge late
    expLat = 2 * `IKS_T_CONV_MIN_US * `IKS_CLK_MHZ + `IKS_CYC_DIGITAL - 8 * `IKS_CYC_SETUP_SYNC;
    syncOnKeyScan = 1'b1;
    wait_upd();
    keyTrigger = k;
    repeat (300) begin
      @(negedge clk);
      if (keysUpdated !== 1'b0 || convCycle !== 2'h0) n++;
    end
    cmp("syncHold", 16'h0000, n[15:0]);
    host_u.scan(`IKS_CYC_SETUP_SYNC);
    cmp("syncOld", {11'h0, resetAck, old[0], old[1], old[2], old[3]}, {11'h0, seen});
    host_u.scan(`IKS_CYC_SETUP_SYNC);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (keysUpdated !== 1'b1 && n < 20000);
    cmp("syncLatency", 16'(expLat), n[15:0]);
    host_u.scan(`IKS_CYC_SETUP_SYNC);
    cmp("syncNew", {11'h0, resetAck, k[0], k[1], k[2], k[3]}, {11'h0, seen});
  endtask : t_sync
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_mode();
    t_period(10'(`IKS_TARGET_DEF), `IKS_T_CYCLE_US * `IKS_CLK_MHZ);
    t_period(10'(`IKS_TARGET_MIN), `IKS_T_CONV_MIN_US * `IKS_CLK_MHZ);
    t_keys(4'hA, 1'b1);
    t_keys(4'h5, 1'b0);
    // The last key scenario leaves the inverse of its pattern behind
    t_sync(4'hA, 4'h6);
    tally_and_finish();
  end
  // Scenarios take about 93k cycles
  initial begin
    repeat (99000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
